// File: design/pdo_pin_cell.sv
// Pin cell: merges port registers with override signals into the pin
// enable, value and pull-up, all registered.
// Assumes override signals on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pdo_pin_cell (
  input wire logic clk,
  input wire logic resetn,
  pdo_ovr_if.rcv ovr,
  input wire logic [7:1] dir,
  input wire logic [7:1] out_reg,
  input wire logic pud,
  output logic [7:1] pin_out,
  output logic [7:1] pin_oe,
  output logic [7:1] pin_pullup
);

  genvar i;
  generate
    for (i = 1; i <= 7; i++)
    begin : g_pin
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          pin_oe[i] <= 1'b0;
          pin_out[i] <= 1'b0;
          pin_pullup[i] <= 1'b0;
        end
        else
        begin
          pin_oe[i] <= ovr.ddoe[i] ? ovr.ddov[i] : dir[i];
          pin_out[i] <= ovr.pvoe[i] ? ovr.pvov[i] : out_reg[i];
          pin_pullup[i] <= ovr.puoe[i] ? ovr.puov[i] : (~dir[i] & out_reg[i] & ~pud);
        end
      end
    end
  endgenerate

endmodule : pdo_pin_cell

`default_nettype wire

// File: design/pdo_port_d.sv
// Port D upper seven pins with peripheral override, register port and
// pin-change interrupt.
// Assumes peripherals on the same clock; pins arrive asynchronously.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pdo_port_d (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [pdo_pkg::ADDR_W-1:0] addr,
  input wire logic [pdo_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pdo_pkg::DATA_W-1:0] rdata,
  output logic irq,
  input wire logic [7:1] pin_in,
  output logic [7:1] pin_out,
  output logic [7:1] pin_oe,
  output logic [7:1] pin_pullup,
  input wire logic tmr2_cmp_a_en,
  input wire logic tmr2_cmp_a_out,
  input wire logic tmr2_cmp_b_en,
  input wire logic tmr2_cmp_b_out,
  input wire logic tmr1_cmp_a_en,
  input wire logic tmr1_cmp_a_out,
  input wire logic tmr1_cmp_b_en,
  input wire logic tmr1_cmp_b_out,
  input wire logic ser2_sync_mode,
  input wire logic ser2_ext_clk_drv,
  input wire logic ser1_sync_mode,
  input wire logic ser1_ext_clk_drv,
  input wire logic spi_b_en,
  input wire logic spi_b_master,
  input wire logic spi_b_clk_drv,
  input wire logic ser1_tx_en,
  input wire logic ser1_tx,
  input wire logic ser1_rx_en,
  input wire logic ser0_tx_en,
  input wire logic ser0_tx,
  output logic tmr1_capture_in,
  output logic ser2_ext_clk,
  output logic ser1_ext_clk,
  output logic spi_b_clk,
  output logic spi_b_select_n,
  output logic ext_irq_one,
  output logic ext_irq_zero,
  output logic ser1_rx,
  output logic pin_chg_src_31,
  output logic pin_chg_src_30,
  output logic pin_chg_src_29,
  output logic pin_chg_src_28,
  output logic pin_chg_src_27,
  output logic pin_chg_src_26,
  output logic pin_chg_src_25
);

  import pdo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [DATA_W-1:0] dir_reg;
  logic [DATA_W-1:0] out_reg;
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] irq_stat;
  logic [DATA_W-1:0] irq_mask;
  logic [DATA_W-1:0] next_irq_stat;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] clear_mask;
  logic [7:1] din;
  logic [7:1] din_prev;
  logic [7:1] pin_change;
  logic pud;
  logic spi_slave;
  logic spi_mast;

  pdo_ovr_if ovr ();

  assign pud = ctrl_reg[CTRL_PUD_BIT];
  assign spi_slave = spi_b_en & ~spi_b_master;
  assign spi_mast = spi_b_en & spi_b_master;

  ////////////////////////////////////////////////////////////////////////////
  // Input path.

  // Every pin passes one shared synchroniser, so all consumers agree.
  pdo_sync #(
    .W(7)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(pin_in),
    .level(din)
  );

  // Common input fan-out
  // The consumers below all read the same registered level in the same cycle.
  assign ser1_rx = din[2];

  assign tmr1_capture_in = din[6];

  // Low-active slave select
  // The far master selects the slave by driving this pin low.
  assign spi_b_select_n = din[6];

  assign spi_b_clk = din[7];

  assign ser2_ext_clk = din[7];

  assign ser1_ext_clk = din[4];

  assign ext_irq_one = din[3];

  assign ext_irq_zero = din[2];

  assign pin_chg_src_31 = din[7];
  assign pin_chg_src_30 = din[6];
  assign pin_chg_src_29 = din[5];
  assign pin_chg_src_28 = din[4];
  assign pin_chg_src_27 = din[3];
  assign pin_chg_src_26 = din[2];
  assign pin_chg_src_25 = din[1];

  ////////////////////////////////////////////////////////////////////////////
  // Override signals for bit 7.

  always_comb
  begin
    ovr.puoe[7] = 1'b0;
    ovr.puov[7] = 1'b0;
    ovr.ddoe[7] = 1'b0;
    ovr.ddov[7] = 1'b0;
    ovr.pvoe[7] = 1'b0;
    ovr.pvov[7] = 1'b0;
    // Slave forces input
    // The pull-up stays with the output register while forced to input.
    if (spi_slave)
    begin
      ovr.ddoe[7] = 1'b1;
      ovr.puoe[7] = 1'b1;
      ovr.puov[7] = out_reg[7] & ~pud;
    end
    if (spi_mast)
    begin
      ovr.pvoe[7] = 1'b1;
      ovr.pvov[7] = spi_b_clk_drv;
    end
    // Timer2 A output
    // Direction is not overridden, so it drives only with its direction set.
    else if (tmr2_cmp_a_en)
    begin
      ovr.pvoe[7] = 1'b1;
      ovr.pvov[7] = tmr2_cmp_a_out;
    end
    else if (ser2_sync_mode)
    begin
      ovr.pvoe[7] = 1'b1;
      ovr.pvov[7] = ser2_ext_clk_drv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override signals for bit 6.

  always_comb
  begin
    ovr.puoe[6] = 1'b0;
    ovr.puov[6] = 1'b0;
    ovr.ddoe[6] = 1'b0;
    ovr.ddov[6] = 1'b0;
    ovr.pvoe[6] = 1'b0;
    ovr.pvov[6] = 1'b0;
    if (spi_slave)
    begin
      ovr.ddoe[6] = 1'b1;
      ovr.puoe[6] = 1'b1;
      ovr.puov[6] = out_reg[6] & ~pud;
    end
    if (tmr2_cmp_b_en)
    begin
      ovr.pvoe[6] = 1'b1;
      ovr.pvov[6] = tmr2_cmp_b_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override signals for bits 5 and 4.

  always_comb
  begin
    ovr.puoe[5] = 1'b0;
    ovr.puov[5] = 1'b0;
    ovr.ddoe[5] = 1'b0;
    ovr.ddov[5] = 1'b0;
    ovr.pvoe[5] = tmr1_cmp_a_en;
    ovr.pvov[5] = tmr1_cmp_a_out;
  end

  always_comb
  begin
    ovr.puoe[4] = 1'b0;
    ovr.puov[4] = 1'b0;
    ovr.ddoe[4] = 1'b0;
    ovr.ddov[4] = 1'b0;
    ovr.pvoe[4] = 1'b0;
    ovr.pvov[4] = 1'b0;
    // Timer1 B then serial1 clock
    // The timer wins when both are on; software should enable only one.
    if (tmr1_cmp_b_en)
    begin
      ovr.pvoe[4] = 1'b1;
      ovr.pvov[4] = tmr1_cmp_b_out;
    end
    else if (ser1_sync_mode)
    begin
      ovr.pvoe[4] = 1'b1;
      ovr.pvov[4] = ser1_ext_clk_drv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override signals for bits 3 to 1.

  always_comb
  begin
    ovr.puoe[3] = ser1_tx_en;
    ovr.puov[3] = 1'b0;
    ovr.ddoe[3] = ser1_tx_en;
    ovr.ddov[3] = 1'b1;
    ovr.pvoe[3] = ser1_tx_en;
    ovr.pvov[3] = ser1_tx;
  end

  always_comb
  begin
    // Receiver forces input
    // The pull-up is left to the bit 2 output register.
    ovr.puoe[2] = ser1_rx_en;
    ovr.puov[2] = out_reg[2] & ~pud;
    ovr.ddoe[2] = ser1_rx_en;
    ovr.ddov[2] = 1'b0;
    ovr.pvoe[2] = 1'b0;
    ovr.pvov[2] = 1'b0;
  end

  always_comb
  begin
    ovr.puoe[1] = ser0_tx_en;
    ovr.puov[1] = 1'b0;
    ovr.ddoe[1] = ser0_tx_en;
    ovr.ddov[1] = 1'b1;
    ovr.pvoe[1] = ser0_tx_en;
    ovr.pvov[1] = ser0_tx;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin cell.

  pdo_pin_cell u_cell (
    .clk(clk),
    .resetn(resetn),
    .ovr(ovr.rcv),
    .dir(dir_reg[7:1]),
    .out_reg(out_reg[7:1]),
    .pud(pud),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_pullup(pin_pullup)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dir_reg <= RST_DIR;
    else if (wr && addr == OFS_DIR)
      dir_reg <= {wdata[7:1], 1'b0};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      out_reg <= RST_OUT;
    else if (wr && addr == OFS_OUT)
      out_reg <= {wdata[7:1], 1'b0};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_reg <= RST_CTRL;
    else if (wr && addr == OFS_CTRL)
      ctrl_reg <= {7'h00, wdata[CTRL_PUD_BIT]};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask <= RST_IRQ;
    else if (wr && addr == OFS_IRQ_MASK)
      irq_mask <= {wdata[7:1], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin-change interrupt.

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      din_prev <= 7'h00;
    else
      din_prev <= din;
  end

  assign pin_change = din ^ din_prev;
  assign clear_mask = (wr && addr == OFS_IRQ_STAT) ? wdata : 8'h00;

  // A change that lands with a clear of the same bit still sets it.
  always_comb
  begin
    next_irq_stat = (irq_stat & ~clear_mask) | {pin_change, 1'b0};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_stat <= RST_IRQ;
    else
      irq_stat <= next_irq_stat;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(next_irq_stat & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  always_comb
  begin
    next_rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        OFS_DIR: next_rdata = dir_reg;
        OFS_OUT: next_rdata = out_reg;
        OFS_PIN: next_rdata = {din, 1'b0};
        OFS_CTRL: next_rdata = ctrl_reg;
        OFS_IRQ_STAT: next_rdata = irq_stat;
        OFS_IRQ_MASK: next_rdata = irq_mask;
        OFS_DRIVE: next_rdata = {pin_oe, 1'b0};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Read data stand for exactly one cycle, zero otherwise.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

endmodule : pdo_port_d

`default_nettype wire

// File: design/pdo_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes only when stages two and
// three agree.
`timescale 1ns/1ps
`default_nettype none

module pdo_sync #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Only the agreeing later stages are looked at, never the first.
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          level[i] <= 1'b0;
        else if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
      end
    end
  endgenerate

endmodule : pdo_sync

`default_nettype wire

// File: dv/pdo_peri_model.sv
// Peripheral stand-in for the port D override block: timer and serial waveforms.
// Assumes the bench owns every enable and mode bit; only the data lines come from here.
`timescale 1ns/1ps
`default_nettype none

module pdo_peri_model #(
  parameter int SLOW = 0
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tmr2_cmp_a_out,
  output logic tmr2_cmp_b_out,
  output logic tmr1_cmp_a_out,
  output logic tmr1_cmp_b_out,
  output logic ser2_ext_clk_drv,
  output logic ser1_ext_clk_drv,
  output logic spi_b_clk_drv,
  output logic ser1_tx,
  output logic ser0_tx
);
  logic [11:0] cnt;

  ////////////////////////////////////////////////////////////
  // Distinct patterns per line, so a swapped route shows at the pins.
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cnt <= 12'h000;
    else
      cnt <= cnt + 12'h001;

  assign tmr2_cmp_a_out = cnt[SLOW];
  assign tmr2_cmp_b_out = cnt[SLOW + 1];
  assign tmr1_cmp_a_out = cnt[SLOW + 2];
  assign tmr1_cmp_b_out = cnt[SLOW] ^ cnt[SLOW + 1];
  assign ser2_ext_clk_drv = ~cnt[SLOW];
  assign ser1_ext_clk_drv = ~cnt[SLOW + 1];
  assign spi_b_clk_drv = cnt[SLOW + 3];
  assign ser1_tx = cnt[SLOW + 2] ^ cnt[SLOW];
  assign ser0_tx = cnt[SLOW + 3] ^ cnt[SLOW + 1];

endmodule : pdo_peri_model

`default_nettype wire

// File: dv/pdo_port_d_assertions.sv
// Checker for the port D override block, bound to its top module.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module pdo_port_d_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:1] pin_in,
  input wire logic [7:1] pin_out,
  input wire logic [7:1] pin_oe,
  input wire logic tmr2_cmp_a_en,
  input wire logic tmr2_cmp_a_out,
  input wire logic tmr2_cmp_b_en,
  input wire logic tmr2_cmp_b_out,
  input wire logic tmr1_cmp_b_en,
  input wire logic tmr1_cmp_b_out,
  input wire logic ser2_sync_mode,
  input wire logic ser2_ext_clk_drv,
  input wire logic spi_b_clk_drv,
  input wire logic tmr1_cmp_a_en,
  input wire logic tmr1_cmp_a_out,
  input wire logic spi_b_en,
  input wire logic spi_b_master,
  input wire logic ser1_tx_en,
  input wire logic ser1_tx,
  input wire logic ser1_rx_en,
  input wire logic ser0_tx_en,
  input wire logic ser0_tx,
  input wire logic tmr1_capture_in,
  input wire logic spi_b_select_n,
  input wire logic ext_irq_one,
  input wire logic ext_irq_zero,
  input wire logic ser1_rx,
  input wire logic pin_chg_src_31,
  input wire logic pin_chg_src_30,
  input wire logic pin_chg_src_27,
  input wire logic pin_chg_src_26
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Synchroniser flops start at zero, so input checks wait out the first edges.
  logic [2:0] up;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;

  ////////////////////////////////////////////////////////////
  property p_tx1;
    ser1_tx_en |=> pin_oe[3] && pin_out[3] == $past(ser1_tx);
  endproperty
  a_tx1: assert property (p_tx1) else $error("bit 3 not driving transmit data");
  property p_tx0;
    ser0_tx_en |=> pin_oe[1] && pin_out[1] == $past(ser0_tx);
  endproperty
  a_tx0: assert property (p_tx0) else $error("bit 1 not driving transmit data");
  property p_rx1;
    ser1_rx_en |=> !pin_oe[2];
  endproperty
  a_rx1: assert property (p_rx1) else $error("bit 2 driven while receiving");
  property p_slv;
    spi_b_en && !spi_b_master |=> pin_oe[7:6] == 2'h0;
  endproperty
  a_slv: assert property (p_slv) else $error("slave pins not forced input");
  property p_tmr1_cmp_a_out;
    tmr1_cmp_a_en |=> !pin_oe[5] || pin_out[5] == $past(tmr1_cmp_a_out);
  endproperty
  a_tmr1_cmp_a_out: assert property (p_tmr1_cmp_a_out) else $error("bit 5 compare output wrong");
  property p_tmr2_cmp_a_out;
    tmr2_cmp_a_en && !spi_b_en |=> !pin_oe[7] || pin_out[7] == $past(tmr2_cmp_a_out);
  endproperty
  a_tmr2_cmp_a_out: assert property (p_tmr2_cmp_a_out) else $error("bit 7 compare output wrong");
  property p_tmr2_cmp_b_out;
    tmr2_cmp_b_en |=> pin_out[6] == $past(tmr2_cmp_b_out);
  endproperty
  a_tmr2_cmp_b_out: assert property (p_tmr2_cmp_b_out) else $error("bit 6 compare output wrong");
  property p_tmr1_cmp_b_out;
    tmr1_cmp_b_en |=> pin_out[4] == $past(tmr1_cmp_b_out);
  endproperty
  a_tmr1_cmp_b_out: assert property (p_tmr1_cmp_b_out) else $error("bit 4 compare output wrong");
  property p_sck;
    spi_b_en && spi_b_master |=> pin_out[7] == $past(spi_b_clk_drv);
  endproperty
  a_sck: assert property (p_sck) else $error("bit 7 master clock wrong");
  // The serial clock reaches the pin only in synchronous mode, below timer and SPI master.
  property p_ser2_ext_clk;
    ser2_sync_mode && !tmr2_cmp_a_en && !spi_b_en |=> pin_out[7] == $past(ser2_ext_clk_drv);
  endproperty
  a_ser2_ext_clk: assert property (p_ser2_ext_clk) else $error("bit 7 serial clock wrong");
  property p_cap;
    tmr1_capture_in == pin_chg_src_30 && spi_b_select_n == pin_chg_src_30;
  endproperty
  a_cap: assert property (p_cap) else $error("bit 6 consumers disagree");
  property p_irq;
    ext_irq_one == pin_chg_src_27 && ext_irq_zero == pin_chg_src_26 && ser1_rx == ext_irq_zero;
  endproperty
  a_irq: assert property (p_irq) else $error("bit 3 or 2 consumers disagree");
  property p_sync;
    (up == 3'h7 && $stable(pin_in)) [*5] |->
      {pin_chg_src_31, pin_chg_src_30, pin_chg_src_27, pin_chg_src_26} ==
      {pin_in[7:6], pin_in[3:2]};
  endproperty
  a_sync: assert property (p_sync) else $error("pin change source lags pin");

  c_tx: cover property (ser1_tx_en && ser0_tx_en);
  c_slv: cover property (spi_b_en && !spi_b_master);
  c_tmr1_cmp_a_out: cover property (tmr1_cmp_a_en && pin_oe[5]);
  c_mst: cover property (spi_b_en && spi_b_master && pin_oe[7]);

endmodule : pdo_port_d_chk

bind pdo_port_d pdo_port_d_chk u_chk (.*);

`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the port D override block.
// Assumes the peripheral model drives all timer and serial data lines.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pdo_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:1] pin_in = 7'h00;
  logic [10:0] en = 11'h000;
  logic [7:0] rdata, rnd, d;
  logic [7:1] pin_out, pin_oe, pin_pullup;
  logic irq, tmr2_cmp_a_out, tmr2_cmp_b_out, tmr1_cmp_a_out, tmr1_cmp_b_out;
  logic ser2_ext_clk_drv, ser1_ext_clk_drv, spi_b_clk_drv, ser1_tx, ser0_tx;
  logic tmr2_cmp_a_en, tmr2_cmp_b_en, tmr1_cmp_a_en, tmr1_cmp_b_en, ser2_sync_mode;
  logic ser1_sync_mode, spi_b_en, spi_b_master, ser1_tx_en, ser1_rx_en, ser0_tx_en;
  logic tmr1_capture_in, ser2_ext_clk, ser1_ext_clk, spi_b_clk, spi_b_select_n;
  logic ext_irq_one, ext_irq_zero, ser1_rx, pin_chg_src_31, pin_chg_src_30;
  logic pin_chg_src_29, pin_chg_src_28, pin_chg_src_27, pin_chg_src_26, pin_chg_src_25;
  logic [7:0] exp_q[$];
  int checks = 0;
  int miscompares = 0;
  logic [7:0] regs[6] = '{OFS_DIR, OFS_OUT, OFS_CTRL, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h1C};

  assign {ser0_tx_en, ser1_rx_en, ser1_tx_en, spi_b_master, spi_b_en, ser1_sync_mode,
    ser2_sync_mode, tmr1_cmp_b_en, tmr1_cmp_a_en, tmr2_cmp_b_en, tmr2_cmp_a_en} = en;
  always #20 clk = ~clk;
  pdo_port_d DUT (.*);
  pdo_peri_model u_model (.*);

  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Only the serial and slave modes may override the direction register.
  function automatic logic [7:0] exp_oe(input logic [7:0] dr, input logic [10:0] e);
    logic [7:0] o;
    o = dr & 8'hFE;
    if (e[6] && !e[7])
      o[7:6] = 2'h0;
    if (e[8])
      o[3] = 1'b1;
    if (e[9])
      o[2] = 1'b0;
    if (e[10])
      o[1] = 1'b1;
    return o;
  endfunction : exp_oe

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t rdata %h expected %h", $time, got, e);
    end
  endtask : cmp_rd

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t pins %h expected %h", $time, got, e);
    end
  endtask : chk_pin

  task automatic print_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge clk)
    rd_q <= rd;
  always @(negedge clk)
    if (rd_q)
      cmp_rd(rdata, exp_q.pop_front());

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict;
  end

  initial
  begin
    rnd = 8'h29;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    wr_reg(8'h1C, 8'hFF);
    foreach (regs[i]) rd_reg(regs[i], 8'h00);
    wr_reg(OFS_DIR, 8'hFF);
    rd_reg(OFS_DIR, 8'hFE);
    $display("registers done");
    for (int i = 0; i < 24; i++)
    begin
      rnd = lfsr(rnd);
      d = rnd;
      wr_reg(OFS_DIR, d);
      rnd = lfsr(rnd);
      en <= {rnd[2:0], lfsr(rnd)};
      repeat (2) @(posedge clk);
      rd_reg(OFS_DRIVE, exp_oe(d, en));
    end
    $display("direction done");
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      pin_in <= rnd[7:1];
      repeat (6) @(posedge clk);
      rd_reg(OFS_PIN, rnd & 8'hFE);
      chk_pin({pin_chg_src_31, pin_chg_src_30, pin_chg_src_29, pin_chg_src_28,
        pin_chg_src_27, pin_chg_src_26, pin_chg_src_25, 1'b0}, rnd & 8'hFE);
      chk_pin({spi_b_clk, ser2_ext_clk, tmr1_capture_in, spi_b_select_n,
        ser1_ext_clk, ext_irq_one, ext_irq_zero, ser1_rx},
        {rnd[7], rnd[7], rnd[6], rnd[6], rnd[4], rnd[3], rnd[2], rnd[2]});
    end
    $display("inputs done");
    en <= 11'h240;
    wr_reg(OFS_DIR, 8'h44);
    wr_reg(OFS_OUT, 8'h44);
    wr_reg(OFS_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    chk_pin({pin_pullup, 1'b0}, 8'h44);
    wr_reg(OFS_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    chk_pin({pin_pullup, 1'b0}, 8'h00);
    $display("pull-up done");
    en <= 11'h000;
    pin_in <= 7'h00;
    repeat (6) @(posedge clk);
    wr_reg(OFS_IRQ_STAT, 8'hFF);
    wr_reg(OFS_IRQ_MASK, 8'h08);
    rd_reg(OFS_IRQ_STAT, 8'h00);
    pin_in <= 7'h10;
    repeat (6) @(posedge clk);
    chk_pin({7'h00, irq}, 8'h00);
    pin_in <= 7'h14;
    repeat (6) @(posedge clk);
    chk_pin({7'h00, irq}, 8'h01);
    wr_reg(OFS_IRQ_STAT, 8'h08);
    @(posedge clk);
    chk_pin({7'h00, irq}, 8'h00);
    rd_reg(OFS_IRQ_STAT, 8'h20);
    repeat (2) @(posedge clk);
    $display("interrupt done");
    print_verdict;
  end

endmodule : tb

`default_nettype wire

// File: inc/pdo_ovr_if.sv
// Override bundle between the override logic and the pin cell.
// Assumes bits 7 to 1 of the port; bit 0 is not carried.
`timescale 1ns/1ps
`default_nettype none

interface pdo_ovr_if;
  logic [7:1] puoe;
  logic [7:1] puov;
  logic [7:1] ddoe;
  logic [7:1] ddov;
  logic [7:1] pvoe;
  logic [7:1] pvov;
  modport drv (output puoe, output puov, output ddoe, output ddov, output pvoe, output pvov);
  modport rcv (input puoe, input puov, input ddoe, input ddov, input pvoe, input pvov);
endinterface : pdo_ovr_if

`default_nettype wire

// File: inc/pdo_pkg.sv
// Constants for the port D override block: register map, reset values,
// field positions and synchroniser depth.
// Assumes a single 25 MHz clock and a byte-wide register port.
`default_nettype none

package pdo_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PIN_LO = 1;
  localparam int PIN_HI = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets, byte addresses.
  localparam logic [ADDR_W-1:0] OFS_DIR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DRIVE = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fields.
  localparam logic [DATA_W-1:0] RST_DIR = 8'h00;
  localparam logic [DATA_W-1:0] RST_OUT = 8'h00;
  localparam logic [DATA_W-1:0] RST_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_IRQ = 8'h00;
  localparam int CTRL_PUD_BIT = 0;

  // Pin synchroniser depth.
  localparam int SYNC_STAGES = 3;

endpackage : pdo_pkg

`default_nettype wire
